// File: dv/fiber_amp_props.sv
`timescale 1ns/10ps
module fiber_amp_props #(
  parameter int UNITS = 14
) (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [UNITS-1:0] amp_on_pin,
  input wire logic [UNITS-1:0] amp_present_pin,
  input wire logic             link_up_pin,
  input wire logic             amp_count_select_pin,
  input wire logic             line_speed_select,
  input wire logic [3:0]       node_setting_pin,
  input wire logic [4:0]       sensor_count_pin,
  input wire logic [7:0]       node_word_lo,
  input wire logic [7:0]       node_word_hi,
  input wire logic [3:0]       node_lo,
  input wire logic [3:0]       node_hi,
  input wire logic             two_word_mode,
  input wire logic             long_distance_mode,
  input wire logic             config_error
);
  logic [2:0] up_ff;
  logic       tw1_ff;
  logic       tw2_ff;
  logic       live;
  logic       steady;

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since reset and layout history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tw1_ff <= 1'b0;
      tw2_ff <= 1'b0;
    end else begin
      tw1_ff <= two_word_mode;
      tw2_ff <= tw1_ff;
    end
  end

  assign live   = (up_ff == 3'h7);
  assign steady = live && (two_word_mode == tw1_ff) && (tw1_ff == tw2_ff);

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  AST_CFG_ERR: assert property (live |-> config_error == ($past(sensor_count_pin, 3) > 5'h0E))
    else $error("config error does not follow selector");
  AST_TWO_WORD: assert property (live |-> two_word_mode == $past(amp_count_select_pin, 3))
    else $error("layout does not follow mode pin");
  AST_LONG_DIST: assert property (live |-> long_distance_mode == $past(line_speed_select, 3))
    else $error("speed mode does not follow speed pin");
  AST_NODE_PAIR: assert property (steady && two_word_mode |->
    (node_lo >> 1) == ($past(node_setting_pin, 3) >> 1) && !node_lo[0] && node_hi == node_lo + 4'h1)
    else $error("two word node pair wrong");
  AST_NODE_ONE: assert property (steady && !two_word_mode |->
    node_lo == $past(node_setting_pin, 3) && node_hi == node_lo)
    else $error("single word node wrong");
  AST_LINK_DOWN: assert property ((!link_up_pin) [*6] |-> node_word_lo == 8'h00 && node_word_hi == 8'h00)
    else $error("words not clear while link down");
  AST_DATA_LO: assert property (steady |-> (node_word_lo & ~$past(amp_on_pin[7:0] & amp_present_pin[7:0], 3)
    & (two_word_mode ? 8'hFF : 8'h3F)) == 8'h00)
    else $error("first word data bit without active amplifier");
  AST_DATA_HI: assert property (steady && two_word_mode |->
    (node_word_hi[5:0] & ~$past(amp_on_pin[13:8] & amp_present_pin[13:8], 3)) == 6'h00)
    else $error("second word data bit without active amplifier");
  AST_SINGLE_HI: assert property (steady && !two_word_mode |-> node_word_hi == 8'h00)
    else $error("second word used in single layout");
  AST_ERR_EST: assert property (steady |-> (two_word_mode ? (!node_word_hi[6] || node_word_hi[7])
    : (!node_word_lo[6] || node_word_lo[7])))
    else $error("error flag without established flag");

  cover property (steady && two_word_mode && node_word_hi[7]);
  cover property (steady && !two_word_mode && node_word_lo[6]);
  cover property (config_error);
endmodule : fiber_amp_props

bind fiber_amp_input_mapper fiber_amp_props #(.UNITS(UNITS)) u_fiber_amp_props (.*);

// File: dv/fieldbus_master_model.sv
`timescale 1ns/10ps
module fieldbus_master_model (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       master_long,
  input wire logic       two_word_mode,
  input wire logic       long_distance_mode,
  input wire logic [3:0] node_lo,
  input wire logic [3:0] node_hi,
  input wire logic [3:0] rd_node,
  input wire logic [7:0] node_word_lo,
  input wire logic [7:0] node_word_hi,
  output logic     [7:0] rd_word
);
  logic [7:0] area_ff [16];

  // Input area refreshed only while both speed modes agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      area_ff <= '{default: 8'h00};
    end else if (master_long == long_distance_mode) begin
      area_ff[node_lo] <= node_word_lo;
      if (two_word_mode) area_ff[node_hi] <= node_word_hi;
    end
  end

  assign rd_word = area_ff[rd_node];
endmodule : fieldbus_master_model

// File: dv/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [13:0] amp_on_pin, amp_present_pin;
  logic        link_up_pin, link_fault_pin, amp_count_select_pin, line_speed_select;
  logic [3:0]  node_setting_pin, node_lo, node_hi, rd_node, nlo, nhi;
  logic [4:0]  sensor_count_pin;
  logic [7:0]  node_word_lo, node_word_hi, rd_word;
  logic        two_word_mode, long_distance_mode, config_error, master_long;
  int          failures, n_tests, cyc;

  fiber_amp_input_mapper u_fiber_amp_input_mapper (.hsize(3'h2), .hready(hreadyout), .*);
  fieldbus_master_model u_fieldbus_master_model (.*);

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= fiber_amp_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic pins(input logic tw, ls, input logic [3:0] nd, input logic [4:0] sel,
                      input logic [13:0] on, pr, input logic up, flt);
    amp_count_select_pin <= tw;
    line_speed_select <= ls;
    node_setting_pin <= nd;
    sensor_count_pin <= sel;
    amp_on_pin <= on;
    amp_present_pin <= pr;
    link_up_pin <= up;
    link_fault_pin <= flt;
    repeat (6) @(posedge hclk);
  endtask : pins

  function automatic logic [15:0] exp_w(input logic tw, est, err, input logic [13:0] v);
    if (tw) return {est, err, v[13:8], v[7:0]};
    return {8'h00, est, err, v[5:0]};
  endfunction : exp_w

  task automatic words(input logic [15:0] e);
    `CHK("node_word_lo", e[7:0], node_word_lo)
    `CHK("node_word_hi", e[15:8], node_word_hi)
    bus(1'b0, fiber_amp_pkg::OFS_WORDS, 32'h0);
    `CHK("words register", e, rd[15:0])
  endtask : words

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, master_long, link_up_pin, link_fault_pin} = 6'h00;
    {amp_count_select_pin, line_speed_select, htrans, haddr, hwdata} = '0;
    {amp_on_pin, amp_present_pin, node_setting_pin, sensor_count_pin, rd_node} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, fiber_amp_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h1, rd)
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    for (int m = 0; m < 4; m++) begin
      pins(m[0], m[1], 4'h5, 5'h06, 14'h0, 14'h0, 1'b0, 1'b0);
      `CHK("two_word_mode", m[0], two_word_mode)
      `CHK("long_distance_mode", m[1], long_distance_mode)
      bus(1'b0, fiber_amp_pkg::OFS_STATUS, 32'h0);
      `CHK("status modes", m[1:0], rd[1:0])
    end
    for (int s = 0; s < 32; s++) begin
      pins(s[4], 1'b0, s[3:0], 5'h06, 14'h0, 14'h0, 1'b0, 1'b0);
      nlo = s[4] ? {s[3:1], 1'b0} : s[3:0];
      nhi = s[4] ? nlo + 4'h1 : nlo;
      `CHK("node_lo", nlo, node_lo)
      `CHK("node_hi", nhi, node_hi)
    end
    bus(1'b0, fiber_amp_pkg::OFS_NODES, 32'h0);
    `CHK("nodes register", {nhi, nlo}, rd[7:0])
    pins(1'b0, 1'b0, 4'h3, 5'h06, 14'h3FFF, 14'h3FFF, 1'b1, 1'b0);
    words(exp_w(1'b0, 1'b1, 1'b0, 14'h3FFF));
    pins(1'b0, 1'b0, 4'h3, 5'h07, 14'h3FFF, 14'h3FFF, 1'b1, 1'b0);
    words(exp_w(1'b0, 1'b1, 1'b1, 14'h3FFF));
    // Two-unit amplifier on positions 3 and 4 counted as two
    pins(1'b1, 1'b0, 4'h5, 5'h0E, 14'h2A5C, 14'h3FFF, 1'b1, 1'b0);
    words(exp_w(1'b1, 1'b1, 1'b0, 14'h2A5C));
    rd_node <= 4'h4;
    @(posedge hclk);
    `CHK("master lower node", 8'h5C, rd_word)
    rd_node <= 4'h5;
    @(posedge hclk);
    `CHK("master upper node", 8'hAA, rd_word)
    pins(1'b1, 1'b0, 4'h5, 5'h0D, 14'h2A5C, 14'h3FF7, 1'b1, 1'b0);
    words(exp_w(1'b1, 1'b1, 1'b0, 14'h2A54));
    pins(1'b1, 1'b0, 4'h5, 5'h0D, 14'h2A5C, 14'h3FF7, 1'b1, 1'b1);
    words(exp_w(1'b1, 1'b1, 1'b1, 14'h2A54));
    pins(1'b1, 1'b0, 4'h5, 5'h0D, 14'h2A5C, 14'h3FF7, 1'b0, 1'b0);
    words(16'h0000);
    // Selector read as plain binary: every value above 14 is invalid
    for (int c = 14; c < 18; c++) begin
      pins(1'b1, 1'b0, 4'h5, c[4:0], 14'h2A5C, 14'h3FFF, 1'b1, 1'b0);
      `CHK("config_error", c > 14, config_error)
      bus(1'b0, fiber_amp_pkg::OFS_STATUS, 32'h0);
      `CHK("status cfg", c > 14, rd[2])
      `CHK("status mismatch", c > 14, rd[3])
      `CHK("status selector", c[4:0], rd[24:20])
    end
    bus(1'b1, fiber_amp_pkg::OFS_CTRL, 32'h0);
    bus(1'b0, fiber_amp_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl written", 32'h0, rd)
    pins(1'b1, 1'b0, 4'h5, 5'h0E, 14'h2A5C, 14'h3FFF, 1'b1, 1'b0);
    words(16'h0000);
    bus(1'b1, fiber_amp_pkg::OFS_CTRL, 32'h1);
    master_long <= 1'b1;
    pins(1'b1, 1'b0, 4'h5, 5'h0E, 14'h0000, 14'h3FFF, 1'b1, 1'b0);
    words(exp_w(1'b1, 1'b1, 1'b0, 14'h0000));
    // Area last refreshed while run was off, fresh value would be 80
    `CHK("stale master area", 8'h00, rd_word)
    stop_test();
  end
endmodule : testbench

// File: verilog/fiber_amp_input_mapper.sv
// Operation
// - Mode pin OFF: up to 6 amplifiers, one 8-bit input word at the node setting.
// - Mode pin ON: up to 14 amplifiers, 16 bits over two consecutive input words.
// - Line-speed pin OFF selects high-speed bus mode, ON selects long-distance mode.
// - Slave and master speed modes must match, else exchange is not guaranteed.
// - Error flag bit 6: count mismatch, or link fault after link established.
// - Established flag bit 7 set once the sensor link is established.
// - Two words: odd setting uses setting-1 and setting, even uses setting and +1.
// - Registered count selector values above 14 are a configuration error.
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module fiber_amp_input_mapper #(
  parameter int UNITS = fiber_amp_pkg::UNITS_MAX
) (
  input  wire logic                               hclk,
  input  wire logic                               hresetn,
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output logic      [31:0]                        hrdata,
  output logic                                    hreadyout,
  output logic                                    hresp,
  input  wire logic [UNITS-1:0]                   amp_on_pin,
  input  wire logic [UNITS-1:0]                   amp_present_pin,
  input  wire logic                               link_up_pin,
  input  wire logic                               link_fault_pin,
  input  wire logic                               amp_count_select_pin,
  input  wire logic                               line_speed_select,
  input  wire logic [fiber_amp_pkg::NODE_W-1:0]   node_setting_pin,
  input  wire logic [fiber_amp_pkg::SEL_W-1:0]    sensor_count_pin,
  output logic      [fiber_amp_pkg::WORD_W-1:0]   node_word_lo,
  output logic      [fiber_amp_pkg::WORD_W-1:0]   node_word_hi,
  output logic      [fiber_amp_pkg::NODE_W-1:0]   node_lo,
  output logic      [fiber_amp_pkg::NODE_W-1:0]   node_hi,
  output logic                                    two_word_mode,
  output logic                                    long_distance_mode,
  output logic                                    config_error
);

  localparam int NW    = fiber_amp_pkg::NODE_W;
  localparam int SW    = fiber_amp_pkg::SEL_W;
  localparam int CW    = fiber_amp_pkg::CNT_W;
  localparam int AW    = fiber_amp_pkg::ADDR_W;
  localparam int PIN_W = 2 * UNITS + 4 + NW + SW;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_sync;
  logic [UNITS-1:0] amp_on;
  logic [UNITS-1:0] amp_present;
  logic             link_up;
  logic             link_fault;
  fiber_amp_pkg::cfg_t cfg;

  assign pins_raw = {amp_on_pin, amp_present_pin, link_up_pin, link_fault_pin,
                     amp_count_select_pin, line_speed_select, node_setting_pin, sensor_count_pin};

  pin_sync #(
    .W (PIN_W)
  ) u_pin_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pins_raw),
    .q       (pins_sync)
  );

  assign {amp_on, amp_present, link_up, link_fault, cfg} = pins_sync;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration check

  logic [UNITS-1:0] present_accepted;
  logic [CW-1:0]    present_count;
  logic             sel_invalid;
  logic             count_mismatch;

  // Positions beyond the active layout are not accepted
  assign present_accepted = amp_present & fiber_amp_pkg::accept_mask(cfg.two_word);
  assign present_count    = fiber_amp_pkg::count_ones(present_accepted);
  assign sel_invalid      = cfg.reg_count > fiber_amp_pkg::SEL_MAX_VALID;
  // Selector holds amplifier units, two-unit models already counted twice
  assign count_mismatch   = sel_invalid || (cfg.reg_count != {1'b0, present_count});

  //////////////////////////////////////////////////////////////////////////////
  // Bus register state

  logic          run_ff;
  logic          wr_pend_ff;
  logic [AW-1:0] wr_addr_ff;
  logic [31:0]   hrdata_ff;
  logic          hreadyout_ff;
  logic          hresp_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Sensor link state

  fiber_amp_pkg::link_state_t state_ff;
  fiber_amp_pkg::link_state_t nxt_state;
  fiber_amp_pkg::link_flags_t flags;
  logic                       link_ok;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fiber_amp_pkg::LINK_WAIT: begin
        if (run_ff && link_up) begin
          nxt_state = fiber_amp_pkg::LINK_UP;
        end
      end
      fiber_amp_pkg::LINK_UP: begin
        if (!run_ff || !link_up) begin
          nxt_state = fiber_amp_pkg::LINK_WAIT;
        end else if (link_fault) begin
          nxt_state = fiber_amp_pkg::LINK_FAULT;
        end
      end
      fiber_amp_pkg::LINK_FAULT: begin
        // Fault holds until run is cleared or the link drops, then the link is rebuilt
        if (!run_ff || !link_up) begin
          nxt_state = fiber_amp_pkg::LINK_WAIT;
        end
      end
      default: begin
        nxt_state = fiber_amp_pkg::LINK_WAIT;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= fiber_amp_pkg::LINK_WAIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign link_ok   = (state_ff != fiber_amp_pkg::LINK_WAIT);
  assign flags.est = link_ok;
  assign flags.err = link_ok && (count_mismatch || (state_ff == fiber_amp_pkg::LINK_FAULT));

  //////////////////////////////////////////////////////////////////////////////
  // Input node words

  node_word_packer #(
    .UNITS (UNITS)
  ) u_packer (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .two_word    (cfg.two_word),
    .link_ok     (link_ok),
    .amp_on      (amp_on),
    .amp_present (amp_present),
    .flags       (flags),
    .word_lo     (node_word_lo),
    .word_hi     (node_word_hi)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Node allocation and bus mode

  logic [NW-1:0] nxt_node_lo;
  logic [NW-1:0] nxt_node_hi;
  logic [NW-1:0] node_lo_ff;
  logic [NW-1:0] node_hi_ff;
  logic          two_word_ff;
  logic          long_dist_ff;
  logic          cfg_err_ff;

  always_comb begin
    nxt_node_lo = cfg.node;
    nxt_node_hi = cfg.node;
    if (cfg.two_word) begin
      if (cfg.node[0]) begin
        nxt_node_lo = cfg.node - {{(NW-1){1'b0}}, 1'b1};
      end else begin
        nxt_node_hi = cfg.node + {{(NW-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      node_lo_ff   <= '0;
      node_hi_ff   <= '0;
      two_word_ff  <= 1'b0;
      long_dist_ff <= 1'b0;
      cfg_err_ff   <= 1'b0;
    end else begin
      node_lo_ff   <= nxt_node_lo;
      node_hi_ff   <= nxt_node_hi;
      two_word_ff  <= cfg.two_word;
      long_dist_ff <= cfg.long_distance;
      cfg_err_ff   <= sel_invalid;
    end
  end

  assign node_lo            = node_lo_ff;
  assign node_hi            = node_hi_ff;
  assign two_word_mode      = two_word_ff;
  assign long_distance_mode = long_dist_ff;
  assign config_error       = cfg_err_ff;

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  logic          addr_phase;
  logic [AW-1:0] addr_lo;
  logic          fwd_run;
  logic [31:0]   nxt_rdata;

  assign addr_phase = hsel && hready && (htrans == fiber_amp_pkg::HTRANS_NONSEQ);
  assign addr_lo    = haddr[AW-1:0];

  // A write to control still in its data phase is forwarded to a read behind it
  assign fwd_run = (wr_pend_ff && (wr_addr_ff == fiber_amp_pkg::OFS_CTRL))
                   ? hwdata[fiber_amp_pkg::CTRL_RUN_BIT] : run_ff;

  always_comb begin
    nxt_rdata = '0;
    case (addr_lo)
      fiber_amp_pkg::OFS_CTRL: begin
        nxt_rdata[fiber_amp_pkg::CTRL_RUN_BIT] = fwd_run;
      end
      fiber_amp_pkg::OFS_STATUS: begin
        nxt_rdata[fiber_amp_pkg::ST_TWO_WORD]  = two_word_ff;
        nxt_rdata[fiber_amp_pkg::ST_LONG_DIST] = long_dist_ff;
        nxt_rdata[fiber_amp_pkg::ST_CFG_ERR]   = cfg_err_ff;
        nxt_rdata[fiber_amp_pkg::ST_MISMATCH]  = count_mismatch;
        nxt_rdata[fiber_amp_pkg::ST_ERR_FLAG]  = flags.err;
        nxt_rdata[fiber_amp_pkg::ST_EST_FLAG]  = flags.est;
        nxt_rdata[fiber_amp_pkg::ST_STATE_LSB +: 3] = state_ff;
        nxt_rdata[fiber_amp_pkg::ST_COUNT_LSB +: CW] = present_count;
        nxt_rdata[fiber_amp_pkg::ST_SEL_LSB +: SW]   = cfg.reg_count;
      end
      fiber_amp_pkg::OFS_WORDS: begin
        nxt_rdata[0 +: fiber_amp_pkg::WORD_W] = node_word_lo;
        nxt_rdata[fiber_amp_pkg::WD_HI_LSB +: fiber_amp_pkg::WORD_W] = node_word_hi;
      end
      fiber_amp_pkg::OFS_NODES: begin
        nxt_rdata[0 +: NW] = node_lo_ff;
        nxt_rdata[fiber_amp_pkg::ND_HI_LSB +: NW] = node_hi_ff;
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      wr_pend_ff <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_ff <= addr_lo;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ff <= fiber_amp_pkg::CTRL_RUN_RST;
    end else if (wr_pend_ff && (wr_addr_ff == fiber_amp_pkg::OFS_CTRL)) begin
      run_ff <= hwdata[fiber_amp_pkg::CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= '0;
    end else if (addr_phase && !hwrite) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= fiber_amp_pkg::HRESP_OKAY;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= fiber_amp_pkg::HRESP_OKAY;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;

endmodule : fiber_amp_input_mapper

// File: verilog/fiber_amp_pkg.sv
package fiber_amp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int UNITS_MAX      = 14;
  localparam int UNITS_SINGLE   = 6;
  localparam int WORD_W         = 8;
  localparam int NODE_W         = 4;
  localparam int SEL_W          = 5;
  localparam int CNT_W          = 4;
  localparam int SYNC_STAGES    = 2;

  // Flag positions inside the word that carries them
  localparam int FLAG_ERR_BIT   = 6;
  localparam int FLAG_EST_BIT   = 7;

  // Largest legal registered sensor count
  localparam logic [SEL_W-1:0] SEL_MAX_VALID = 5'h0E;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int ADDR_W         = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WORDS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_NODES  = 8'h0C;

  localparam int CTRL_RUN_BIT   = 0;
  localparam logic CTRL_RUN_RST = 1'b1;

  localparam int ST_TWO_WORD    = 0;
  localparam int ST_LONG_DIST   = 1;
  localparam int ST_CFG_ERR     = 2;
  localparam int ST_MISMATCH    = 3;
  localparam int ST_ERR_FLAG    = 4;
  localparam int ST_EST_FLAG    = 5;
  localparam int ST_STATE_LSB   = 8;
  localparam int ST_COUNT_LSB   = 16;
  localparam int ST_SEL_LSB     = 20;
  localparam int WD_HI_LSB      = 8;
  localparam int ND_HI_LSB      = 4;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    LINK_WAIT  = 3'h1,
    LINK_UP    = 3'h2,
    LINK_FAULT = 3'h4
  } link_state_t;

  typedef struct packed {
    logic              two_word;
    logic              long_distance;
    logic [NODE_W-1:0] node;
    logic [SEL_W-1:0]  reg_count;
  } cfg_t;

  typedef struct packed {
    logic est;
    logic err;
  } link_flags_t;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [CNT_W-1:0] count_ones(input logic [UNITS_MAX-1:0] v);
    logic [CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < UNITS_MAX; i++) begin
      n = n + {{(CNT_W-1){1'b0}}, v[i]};
    end
    return n;
  endfunction : count_ones

  function automatic logic [UNITS_MAX-1:0] accept_mask(input logic two_word);
    logic [UNITS_MAX-1:0] m;
    m = '0;
    for (int i = 0; i < UNITS_MAX; i++) begin
      m[i] = two_word || (i < UNITS_SINGLE);
    end
    return m;
  endfunction : accept_mask

endpackage : fiber_amp_pkg

// File: verilog/node_word_packer.sv
`timescale 1ns/10ps
module node_word_packer #(
  parameter int UNITS = fiber_amp_pkg::UNITS_MAX
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       two_word,
  input  wire logic                       link_ok,
  input  wire logic [UNITS-1:0]           amp_on,
  input  wire logic [UNITS-1:0]           amp_present,
  input  wire fiber_amp_pkg::link_flags_t flags,
  output logic [fiber_amp_pkg::WORD_W-1:0] word_lo,
  output logic [fiber_amp_pkg::WORD_W-1:0] word_hi
);

  localparam int WW = fiber_amp_pkg::WORD_W;

  logic [UNITS-1:0] data;
  logic [WW-1:0]    nxt_lo;
  logic [WW-1:0]    nxt_hi;
  logic [WW-1:0]    word_lo_ff;
  logic [WW-1:0]    word_hi_ff;

  always_comb begin
    data   = amp_on & amp_present & fiber_amp_pkg::accept_mask(two_word) & {UNITS{link_ok}};
    nxt_lo = '0;
    nxt_hi = '0;
    if (two_word) begin
      nxt_lo = data[WW-1:0];
      nxt_hi[fiber_amp_pkg::UNITS_SINGLE-1:0] = data[UNITS-1:WW];
      nxt_hi[fiber_amp_pkg::FLAG_ERR_BIT]     = flags.err;
      nxt_hi[fiber_amp_pkg::FLAG_EST_BIT]     = flags.est;
    end else begin
      nxt_lo[fiber_amp_pkg::UNITS_SINGLE-1:0] = data[fiber_amp_pkg::UNITS_SINGLE-1:0];
      nxt_lo[fiber_amp_pkg::FLAG_ERR_BIT]     = flags.err;
      nxt_lo[fiber_amp_pkg::FLAG_EST_BIT]     = flags.est;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_lo_ff <= '0;
      word_hi_ff <= '0;
    end else begin
      word_lo_ff <= nxt_lo;
      word_hi_ff <= nxt_hi;
    end
  end

  assign word_lo = word_lo_ff;
  assign word_hi = word_hi_ff;

endmodule : node_word_packer

// File: verilog/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // Two-stage capture of pins from outside the clock domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : pin_sync
